// File: include/motion_pkg.sv
// Behaviour
// - Standby stops sampling and processing
// - Standby keeps unread data and flags
// - Reset lands in standby, sensing off
// - Measurement output rate 12.5 to 400 Hz
// - Rate reduction averages, never skips samples
// - Wake-up mode measures six times per second
// - Wake-up mode bypasses the activity timer
// - Wake-up keeps registers and live data
// - Normal, low and ultralow noise settings
// - Events set status flags, optionally interrupt
// - Motion state flag shows awake or asleep
// - Detection runs in measurement and wake-up
// - Activity needs threshold held for activity time
// - Absolute activity: any axis over threshold
// - Referenced activity captures first engaged sample
// - Referenced activity: deviation at least threshold
// - Inactivity needs below-threshold for inactivity time
// - Absolute inactivity compares samples with threshold
// - Referenced inactivity references first engaged sample
// - Staying inside band for time means asleep
// - Sample outside band becomes new reference
// - Activity sets awake, inactivity sets asleep
// - Linked mode alternates, needs host service
// - Loop mode alternates without host service
// - Event outputs OR mapped sources, selectable polarity
package motion_pkg;

  localparam int unsigned SYS_CLK_HZ      = 25_000_000;
  localparam int unsigned WAKE_RATE_HZ    = 6;
  localparam int unsigned WAKE_PERIOD_CYC = SYS_CLK_HZ / WAKE_RATE_HZ;

  localparam int AXIS_W       = 12;
  localparam int ACC_W        = 17;
  localparam int THR_W        = 11;
  localparam int ACT_TIME_W   = 8;
  localparam int INACT_TIME_W = 16;

  localparam logic [2:0] ODR_SLOWEST = 3'h5;

  localparam logic [5:0] OFF_CTRL       = 6'h00;
  localparam logic [5:0] OFF_ACT_THR    = 6'h04;
  localparam logic [5:0] OFF_ACT_TIME   = 6'h08;
  localparam logic [5:0] OFF_INACT_THR  = 6'h0C;
  localparam logic [5:0] OFF_INACT_TIME = 6'h10;
  localparam logic [5:0] OFF_MAP1       = 6'h14;
  localparam logic [5:0] OFF_MAP2       = 6'h18;
  localparam logic [5:0] OFF_STATUS     = 6'h1C;
  localparam logic [5:0] OFF_DATA_X     = 6'h20;
  localparam logic [5:0] OFF_DATA_Y     = 6'h24;
  localparam logic [5:0] OFF_DATA_Z     = 6'h28;

  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_NOISE_LSB = 2;
  localparam int CTRL_ODR_LSB   = 4;
  localparam int CTRL_ACT_REF   = 8;
  localparam int CTRL_INACT_REF = 9;
  localparam int CTRL_LINK_LSB  = 10;
  localparam logic [11:0] CTRL_MASK = 12'hF7F;
  localparam logic [11:0] CTRL_RST  = 12'h000;

  localparam logic [1:0] OPC_MEASURE  = 2'h2;
  localparam logic [1:0] OPC_WAKE     = 2'h3;
  localparam logic [1:0] LINK_DEFAULT = 2'h0;
  localparam logic [1:0] LINK_LOOP    = 2'h2;

  localparam int MAP_ACT   = 0;
  localparam int MAP_INACT = 1;
  localparam int MAP_AWAKE = 2;
  localparam int MAP_LOW   = 7;
  localparam logic [7:0] MAP_MASK = 8'h87;
  localparam logic [7:0] MAP_RST  = 8'h00;

  localparam int ST_ACT   = 0;
  localparam int ST_INACT = 1;
  localparam int ST_AWAKE = 2;
  localparam int ST_DRDY  = 3;

  localparam logic [THR_W-1:0]        THR_RST        = 11'h000;
  localparam logic [ACT_TIME_W-1:0]   ACT_TIME_RST   = 8'h00;
  localparam logic [INACT_TIME_W-1:0] INACT_TIME_RST = 16'h0000;

  typedef logic [AXIS_W-1:0] axis_t;

  typedef struct packed {
    axis_t [2:0] axis;
  } accel_t;

  typedef enum logic [2:0] {
    OP_STANDBY = 3'b001,
    OP_MEASURE = 3'b010,
    OP_WAKE    = 3'b100
  } op_state_t;

  function automatic axis_t mag_diff(axis_t a, axis_t b, logic use_ref);
    logic signed [AXIS_W:0] d;
    d = $signed({a[AXIS_W-1], a}) - (use_ref ? $signed({b[AXIS_W-1], b}) : 13'sh0000);
    mag_diff = d[AXIS_W] ? AXIS_W'(-d) : AXIS_W'(d);
  endfunction

  function automatic logic [ACC_W-1:0] sext_acc(axis_t a);
    sext_acc = {{(ACC_W - AXIS_W){a[AXIS_W-1]}}, a};
  endfunction

  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction

endpackage

// File: hw/motion_compare.sv
module motion_compare
  import motion_pkg::*;
(
  input  wire accel_t           sample_in,
  input  wire accel_t           ref_in,
  input  wire logic             use_ref_in,
  input  wire logic [THR_W-1:0] thresh_in,
  output logic                  above_any_out,
  output logic                  below_all_out
);

  logic [AXIS_W-1:0] mag;
  logic [AXIS_W-1:0] thr_ext;

  assign thr_ext = {1'b0, thresh_in};

  always_comb begin
    mag           = '0;
    above_any_out = 1'b0;
    below_all_out = 1'b1;
    for (int i = 0; i < 3; i++) begin
      mag = mag_diff(sample_in.axis[i], ref_in.axis[i], use_ref_in);
      // Referenced compare is inclusive so an exact threshold step counts
      if (use_ref_in ? (mag >= thr_ext) : (mag > thr_ext)) begin
        above_any_out = 1'b1;
      end
      if (use_ref_in ? (mag > thr_ext) : (mag >= thr_ext)) begin
        below_all_out = 1'b0;
      end
    end
  end

endmodule // motion_compare

// File: hw/motion_activity_detector.sv
module motion_activity_detector
  import motion_pkg::*;
#(
  parameter int unsigned WAKE_PERIOD = WAKE_PERIOD_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        sample_valid_in,
  input  wire accel_t      sample_in,
  output logic             front_enable_out,
  output logic      [1:0]  noise_mode_out,
  output logic             awake_out,
  output logic             first_event_output_out,
  output logic             first_event_output_oe_n_out,
  output logic             second_event_output_out,
  output logic             second_event_output_oe_n_out
);

  localparam int WAKE_W = (WAKE_PERIOD > 1) ? $clog2(WAKE_PERIOD) : 1;

  ////////////////////////////////////////////////////////////////////////////
  logic                    pend_r;
  logic [31:0]             readdata_r;
  logic [11:0]             ctrl_r;
  logic [THR_W-1:0]        act_thr_r;
  logic [THR_W-1:0]        inact_thr_r;
  logic [ACT_TIME_W-1:0]   act_time_r;
  logic [INACT_TIME_W-1:0] inact_time_r;
  logic [7:0]              map1_r;
  logic [7:0]              map2_r;
  op_state_t               op_r;
  op_state_t               op_nxt;
  logic [31:0]             rd_word;
  logic [31:0]             wr_word;
  logic [2:0][ACC_W-1:0]   acc_r;
  logic [2:0][ACC_W-1:0]   sum_nxt;
  accel_t                  avg_s;
  logic [4:0]              avg_cnt_r;
  logic [WAKE_W-1:0]       wake_cnt_r;
  accel_t                  last_r;
  logic                    have_r;
  accel_t                  data_r;
  logic                    drdy_r;
  accel_t                  act_ref_r;
  logic                    act_ref_ok_r;
  accel_t                  inact_ref_r;
  logic                    inact_ref_ok_r;
  logic [ACT_TIME_W:0]     act_cnt_r;
  logic [INACT_TIME_W:0]   inact_cnt_r;
  logic                    awake_r;
  logic                    act_flag_r;
  logic                    inact_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, read data registered before release
  wire req     = avs_read_in | avs_write_in;
  wire take    = req & pend_r;
  wire wr_take = take & avs_write_in;
  wire rd_take = take & avs_read_in;

  assign avs_waitrequest_out = req & ~pend_r;
  assign avs_readdata_out    = readdata_r;

  always_comb begin
    unique case (avs_address_in)
      OFF_CTRL:       rd_word = {20'h00000, ctrl_r};
      OFF_ACT_THR:    rd_word = {21'h000000, act_thr_r};
      OFF_ACT_TIME:   rd_word = {24'h000000, act_time_r};
      OFF_INACT_THR:  rd_word = {21'h000000, inact_thr_r};
      OFF_INACT_TIME: rd_word = {16'h0000, inact_time_r};
      OFF_MAP1:       rd_word = {24'h000000, map1_r};
      OFF_MAP2:       rd_word = {24'h000000, map2_r};
      OFF_STATUS:     rd_word = {28'h0000000, drdy_r, awake_r, inact_flag_r, act_flag_r};
      OFF_DATA_X:     rd_word = {20'h00000, data_r.axis[0]};
      OFF_DATA_Y:     rd_word = {20'h00000, data_r.axis[1]};
      OFF_DATA_Z:     rd_word = {20'h00000, data_r.axis[2]};
      default:        rd_word = 32'h00000000;
    endcase
  end

  assign wr_word = be_merge(rd_word, avs_writedata_in, avs_byteenable_in);

  wire wr_ctrl   = wr_take & (avs_address_in == OFF_CTRL);
  wire st_clr    = rd_take & (avs_address_in == OFF_STATUS);
  wire data_clr  = rd_take & (avs_address_in == OFF_DATA_X);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_r     <= 1'b0;
      readdata_r <= 32'h00000000;
    end else begin
      pend_r <= req & ~pend_r;
      if (req & ~pend_r) begin
        readdata_r <= rd_word;
      end
    end
  end

  // Registers stay writable in every mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r       <= CTRL_RST;
      act_thr_r    <= THR_RST;
      inact_thr_r  <= THR_RST;
      act_time_r   <= ACT_TIME_RST;
      inact_time_r <= INACT_TIME_RST;
      map1_r       <= MAP_RST;
      map2_r       <= MAP_RST;
    end else if (wr_take) begin
      unique case (avs_address_in)
        OFF_CTRL:       ctrl_r <= wr_word[11:0] & CTRL_MASK;
        OFF_ACT_THR:    act_thr_r <= wr_word[THR_W-1:0];
        OFF_ACT_TIME:   act_time_r <= wr_word[ACT_TIME_W-1:0];
        OFF_INACT_THR:  inact_thr_r <= wr_word[THR_W-1:0];
        OFF_INACT_TIME: inact_time_r <= wr_word[INACT_TIME_W-1:0];
        OFF_MAP1:       map1_r <= wr_word[7:0] & MAP_MASK;
        OFF_MAP2:       map2_r <= wr_word[7:0] & MAP_MASK;
        default:        ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  wire [1:0] op_code   = ctrl_r[CTRL_OP_LSB +: 2];
  wire [2:0] odr_raw   = ctrl_r[CTRL_ODR_LSB +: 3];
  wire [2:0] odr       = (odr_raw > ODR_SLOWEST) ? ODR_SLOWEST : odr_raw;
  wire       act_refm  = ctrl_r[CTRL_ACT_REF];
  wire       inact_refm = ctrl_r[CTRL_INACT_REF];
  wire [1:0] link      = ctrl_r[CTRL_LINK_LSB +: 2];
  wire       link_free = (link == LINK_DEFAULT);
  wire       link_loop = (link == LINK_LOOP);

  assign noise_mode_out = ctrl_r[CTRL_NOISE_LSB +: 2];

  always_comb begin
    unique case (op_code)
      OPC_MEASURE: op_nxt = OP_MEASURE;
      OPC_WAKE:    op_nxt = OP_WAKE;
      default:     op_nxt = OP_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_r <= OP_STANDBY;
    end else begin
      op_r <= op_nxt;
    end
  end

  wire standby = (op_r == OP_STANDBY);
  wire meas    = (op_r == OP_MEASURE);
  wire wake    = (op_r == OP_WAKE);

  assign front_enable_out = ~standby;

  ////////////////////////////////////////////////////////////////////////////
  // Averaging decimator: every front-end sample is summed
  wire [5:0] span    = 6'h01 << odr;
  wire [4:0] avg_end = 5'(span - 6'h01);
  wire       odr_tick = meas & sample_valid_in & (avg_cnt_r == avg_end);
  wire       wake_tick = wake & (wake_cnt_r == WAKE_W'(WAKE_PERIOD - 1));

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sum_nxt[i]      = acc_r[i] + sext_acc(sample_in.axis[i]);
      avg_s.axis[i]   = AXIS_W'($signed(sum_nxt[i]) >>> odr);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r     <= '0;
      avg_cnt_r <= 5'h00;
    end else if (!meas || odr_tick) begin
      acc_r     <= '0;
      avg_cnt_r <= 5'h00;
    end else if (sample_valid_in) begin
      acc_r     <= sum_nxt;
      avg_cnt_r <= avg_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_cnt_r <= '0;
    end else if (!wake || wake_tick) begin
      wake_cnt_r <= '0;
    end else begin
      wake_cnt_r <= wake_cnt_r + WAKE_W'(1);
    end
  end

  // Wake-up uses the newest raw sample; the ODR divider does not run there
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_r <= '0;
      have_r <= 1'b0;
    end else if (standby) begin
      have_r <= 1'b0;
    end else if (sample_valid_in) begin
      last_r <= sample_in;
      have_r <= 1'b1;
    end
  end

  wire    det_tick = odr_tick | (wake_tick & have_r);
  accel_t det_s;
  assign  det_s = meas ? avg_s : last_r;

  // Output data hold their value through standby
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_r <= '0;
      drdy_r <= 1'b0;
    end else begin
      if (det_tick) begin
        data_r <= det_s;
      end
      drdy_r <= det_tick | (drdy_r & ~data_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity path
  wire act_armed   = link_free | (~awake_r & (link_loop | ~inact_flag_r));
  wire inact_armed = link_free | (awake_r & (link_loop | ~act_flag_r));
  wire act_hit;
  wire inact_ok;
  wire unused_act_below;
  wire unused_inact_above;

  motion_compare u_act (
    .sample_in     (det_s),
    .ref_in        (act_ref_r),
    .use_ref_in    (act_refm),
    .thresh_in     (act_thr_r),
    .above_any_out (act_hit),
    .below_all_out (unused_act_below)
  );

  wire act_cap  = det_tick & act_armed & act_refm & ~act_ref_ok_r;
  wire act_step = det_tick & act_armed & (~act_refm | act_ref_ok_r);
  wire [ACT_TIME_W:0] act_need = (act_time_r == ACT_TIME_RST) ? 9'h001 : {1'b0, act_time_r};
  wire [ACT_TIME_W:0] act_cnt_nxt = act_cnt_r + 9'h001;
  // Dwell timer is bypassed in wake-up mode
  wire act_evt  = act_step & act_hit & (wake | (act_cnt_nxt >= act_need));

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_ref_r    <= '0;
      act_ref_ok_r <= 1'b0;
      act_cnt_r    <= '0;
    end else begin
      if (act_cap) begin
        act_ref_r    <= det_s;
        act_ref_ok_r <= 1'b1;
      end else if (!act_armed || standby) begin
        act_ref_ok_r <= 1'b0;
      end
      if (!act_armed || act_evt || (act_step && !act_hit)) begin
        act_cnt_r <= '0;
      end else if (act_step) begin
        act_cnt_r <= act_cnt_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inactivity path
  motion_compare u_inact (
    .sample_in     (det_s),
    .ref_in        (inact_ref_r),
    .use_ref_in    (inact_refm),
    .thresh_in     (inact_thr_r),
    .above_any_out (unused_inact_above),
    .below_all_out (inact_ok)
  );

  wire inact_cap  = det_tick & inact_armed & inact_refm & ~inact_ref_ok_r;
  wire inact_step = det_tick & inact_armed & (~inact_refm | inact_ref_ok_r);
  wire inact_miss = inact_step & ~inact_ok;
  wire [INACT_TIME_W:0] inact_need =
    (inact_time_r == INACT_TIME_RST) ? 17'h00001 : {1'b0, inact_time_r};
  wire [INACT_TIME_W:0] inact_cnt_nxt = inact_cnt_r + 17'h00001;
  wire inact_evt = inact_step & inact_ok & (inact_cnt_nxt >= inact_need);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inact_ref_r    <= '0;
      inact_ref_ok_r <= 1'b0;
      inact_cnt_r    <= '0;
    end else begin
      // New awake state forces a fresh reference
      if (act_evt || !inact_armed || standby) begin
        inact_ref_ok_r <= 1'b0;
      end else if (inact_cap || (inact_miss && inact_refm)) begin
        inact_ref_r    <= det_s;
        inact_ref_ok_r <= 1'b1;
      end
      if (act_evt || !inact_armed || inact_evt || inact_miss) begin
        inact_cnt_r <= '0;
      end else if (inact_step) begin
        inact_cnt_r <= inact_cnt_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion state and sticky flags; a new event beats a status read
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      awake_r      <= 1'b0;
      act_flag_r   <= 1'b0;
      inact_flag_r <= 1'b0;
    end else begin
      if (act_evt) begin
        awake_r <= 1'b1;
      end else if (inact_evt) begin
        awake_r <= 1'b0;
      end
      act_flag_r   <= act_evt | (act_flag_r & ~st_clr);
      inact_flag_r <= inact_evt | (inact_flag_r & ~st_clr);
    end
  end

  assign awake_out = awake_r;

  function automatic logic pin_level(logic [7:0] map, logic [2:0] src);
    pin_level = (|(map[MAP_AWAKE:MAP_ACT] & src)) ^ map[MAP_LOW];
  endfunction

  // Unmapped pin floats; enable low means driving
  wire [2:0] src = {awake_r, inact_flag_r, act_flag_r};
  assign first_event_output_out       = pin_level(map1_r, src);
  assign first_event_output_oe_n_out  = ~|map1_r[MAP_AWAKE:MAP_ACT];
  assign second_event_output_out      = pin_level(map2_r, src);
  assign second_event_output_oe_n_out = ~|map2_r[MAP_AWAKE:MAP_ACT];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_standby_idle: assert property (standby |-> !det_tick && !act_evt && !inact_evt)
    else $error("detection ran in standby");
  chk_standby_keep: assert property (standby && !st_clr && !data_clr |=>
      $stable(act_flag_r) && $stable(inact_flag_r) && $stable(data_r))
    else $error("standby lost pending state");
  chk_front_off: assert property (front_enable_out == !standby)
    else $error("front end enable wrong");
  chk_odr_range: assert property (odr_tick |-> meas && odr <= ODR_SLOWEST)
    else $error("output rate out of range");
  chk_wake_tick: assert property (wake && det_tick |-> wake_tick && !odr_tick)
    else $error("wake detection off schedule");
  chk_act_dwell: assert property (act_evt && meas |->
      act_hit && act_cnt_r + 9'h001 >= act_need)
    else $error("activity without dwell");
  chk_awake_track: assert property (act_evt |=> awake_r && act_flag_r)
    else $error("activity did not wake");
  chk_sleep_track: assert property (inact_evt && !act_evt |=> !awake_r && inact_flag_r)
    else $error("inactivity did not sleep");
  chk_dwell_clear: assert property (act_step && !act_hit |=> act_cnt_r == '0)
    else $error("dwell count kept after miss");
  chk_band_rebase: assert property (inact_miss && inact_refm && !act_evt |=>
      inact_ref_r == $past(det_s) && inact_cnt_r == '0)
    else $error("band miss did not rebase");
  chk_link_gate: assert property (!link_free && !link_loop && inact_flag_r |-> !act_evt)
    else $error("linked rearm before service");
  chk_pin_or: assert property (!first_event_output_oe_n_out |->
      first_event_output_out == ((|(map1_r[2:0] & src)) ^ map1_r[MAP_LOW]))
    else $error("event pin level wrong");

  cov_act_meas:  cover property (meas && act_evt);
  cov_inact_evt: cover property (inact_evt);
  cov_wake_act:  cover property (wake && act_evt);
  cov_loop_alt:  cover property (link_loop && act_evt ##[1:1000] inact_evt);

endmodule // motion_activity_detector

// File: bench/switch_enable_model.sv
module switch_enable_model (
  input  wire logic pin_in,
  input  wire logic oe_n_in,
  output logic      enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-down on the enable: a released pin turns the load off
  assign enable_out = oe_n_in ? 1'b0 : pin_in;
endmodule // switch_enable_model

// File: bench/motion_activity_detector_tb_top.sv
module motion_activity_detector_tb_top;
  import motion_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, rd = 1'b0, wr = 1'b0, sv = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  logic        wreq, fe, awk, p1, p1oe, p2, p2oe, sw_en;
  logic [1:0]  noise;
  accel_t      smp = '0;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////
  motion_activity_detector #(.WAKE_PERIOD(50)) dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .sample_valid_in(sv), .sample_in(smp), .front_enable_out(fe), .noise_mode_out(noise),
    .awake_out(awk), .first_event_output_out(p1), .first_event_output_oe_n_out(p1oe),
    .second_event_output_out(p2), .second_event_output_oe_n_out(p2oe));
  switch_enable_model load_sw (.pin_in(p1), .oe_n_in(p1oe), .enable_out(sw_en));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    @(posedge sys_clk_in);
    // No wait count assumed; the run ceiling ends a hang
    while (wreq !== 1'b0) begin
      @(posedge sys_clk_in);
    end
    q = rdata;
    wr <= 1'b0; rd <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic send(input logic [11:0] v);
    smp <= '{axis: '{v, v, v}}; sv <= 1'b1;
    @(posedge sys_clk_in);
    sv <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset_standby;
    chk("front_enable", 0, fe);
    chk("pin1 oe_n", 1, p1oe);
    bus(0, OFF_CTRL, 0); chk("ctrl", 0, q);
    send(12'h7FF);
    bus(0, OFF_STATUS, 0); chk("status", 0, q);
    bus(0, OFF_DATA_X, 0); chk("data_x", 0, q);
    bus(0, 6'h3C, 0); chk("unmapped", 0, q);
    $display("test reset_standby done");
  endtask
  task automatic t_noise_rate;
    // Top threshold keeps the motion state asleep for later tests
    bus(1, OFF_ACT_THR, 32'h7FF);
    for (int m = 0; m < 3; m++) begin
      bus(1, OFF_CTRL, 32'h2 | (m << 2)); chk("noise", m, noise);
    end
    bus(1, OFF_CTRL, 32'h012);
    send(12'h064);
    bus(0, OFF_STATUS, 0); chk("drdy half", 0, q[ST_DRDY]);
    send(12'h12C);
    bus(0, OFF_DATA_X, 0); chk("avg x", 32'h0C8, q);
    $display("test noise_rate done");
  endtask
  task automatic t_act_inact;
    bus(1, OFF_CTRL, 32'h002); bus(1, OFF_ACT_THR, 32'h064); bus(1, OFF_ACT_TIME, 32'h2);
    bus(1, OFF_INACT_THR, 32'h032); bus(1, OFF_INACT_TIME, 32'h3); bus(1, OFF_MAP1, 32'h04);
    bus(0, OFF_STATUS, 0);
    send(12'h0C8); send(12'h00A); send(12'h0C8);
    bus(0, OFF_STATUS, 0); chk("no act yet", 0, q[2:0]);
    send(12'h0C8);
    bus(0, OFF_STATUS, 0); chk("act", 32'h5, q[2:0]);
    chk("awake", 1, awk);
    chk("switch on", 1, sw_en);
    send(12'h00A); send(12'h00A);
    chk("still awake", 1, awk);
    send(12'h00A);
    chk("asleep", 0, awk);
    chk("switch off", 0, sw_en);
    bus(1, OFF_CTRL, 0);
    // Mode state follows the control word one edge later
    @(posedge sys_clk_in);
    chk("fe standby", 0, fe);
    bus(0, OFF_STATUS, 0); chk("kept", 32'hA, q[3:0]);
    $display("test act_inact done");
  endtask
  task automatic t_wake;
    bus(1, OFF_ACT_TIME, 32'h4); bus(1, OFF_CTRL, 32'h003);
    @(posedge sys_clk_in);
    chk("fe wake", 1, fe);
    send(12'h0C8);
    repeat (60) @(posedge sys_clk_in);
    bus(0, OFF_STATUS, 0); chk("wake act", 32'h5, q[2:0]);
    $display("test wake done");
  endtask
  task automatic t_ref_link;
    bus(1, OFF_ACT_TIME, 32'h1); bus(1, OFF_MAP2, 32'h81); bus(1, OFF_CTRL, 32'hB02);
    send(12'h3E8); send(12'h3FC); send(12'h44C); send(12'h460); send(12'h442);
    chk("band hold", 1, awk);
    send(12'h456);
    chk("band sleep", 0, awk);
    send(12'h4B0);
    chk("ref capture", 0, awk);
    send(12'h513);
    chk("ref below", 0, awk);
    send(12'h514);
    chk("ref wake", 1, awk);
    chk("pin2 act low", 0, p2);
    chk("pin2 oe_n", 0, p2oe);
    bus(1, OFF_CTRL, 32'h702);
    repeat (4) send(12'h514);
    chk("linked hold", 1, awk);
    bus(0, OFF_STATUS, 0); chk("linked flags", 32'h7, q[2:0]);
    chk("pin2 idle", 1, p2);
    repeat (4) send(12'h514);
    chk("linked sleep", 0, awk);
    $display("test ref_link done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole run needs under 300 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    t_reset_standby();
    t_noise_rate();
    t_act_inact();
    t_wake();
    t_ref_link();
    close_out();
  end
endmodule // motion_activity_detector_tb_top
